// file: src/scs_top.sv
`timescale 1ns/1ps
module scs_top #(
    parameter bit DNZ_SUPPORTED = 1'b1
) (
    // clock, reset, enable
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic            clk_en,
    // soft init pin, active low
    input  wire logic            init_n,
    // system enable for vector state handling
    input  wire logic            os_vec_enable,
    // operation request
    input  wire logic            req_valid,
    input  scs_pkg::scs_req_t    req,
    // save image memory port
    output scs_pkg::scs_mem_t    mem,
    input  wire logic [31:0]     mem_rdata,
    // answer and state
    output scs_pkg::scs_rsp_t    rsp,
    output logic                 busy,
    output logic [31:0]          simd_control_status,
    output logic [31:0]          flags_register
);
    import scs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // block overview
    // - one request is taken per idle cycle while busy is low
    // - single-cycle ops answer with a done pulse one cycle later
    // - save and restore walk the 128-word image one word a cycle
    // - requests that arrive while busy are dropped, not queued
    //
    // image word map, 32-bit words
    // - word 6 holds the control/status value
    // - word 7 holds the reported reserved-bit mask
    // - words 40 to 71 hold the eight vector registers
    // - register n lane l sits at word 40 + 4n + l
    // - lane 0 is bits 31:0 of the register
    // - every other word is written as zero on save
    // - every other word is ignored on restore
    //
    // restore pipeline
    // - the read for word k is shown on the port for one cycle
    // - the memory answers within that same cycle
    // - so the data for word k is sampled at the following edge
    // - rptr trails ptr by one word for that reason
    // - the status value is staged and applied only at the end
    // - a staged value with a reserved bit faults as a whole
    //   and leaves the live register untouched
    //
    // trade-offs and limits
    // - the mask is a build-time constant, never derived from
    //   the live register, so software always sees one answer
    // - the denormal-zero control is only stored here; no
    //   arithmetic in this block looks at it
    // - soft init is wired but deliberately ignored: all state
    //   here survives it, only hardware reset clears it
    // - clk_en low freezes every flop, including the image walk,
    //   so the memory must hold its answer while frozen
    // - the flags register only keeps bit 21; other bits read 0
    // - busy leaves from a flop, fed from the next state, so it
    //   rises in the same cycle the walk starts
    //

    typedef enum logic [1:0] {SCS_IDLE, SCS_SAVE, SCS_REST, SCS_RWAIT} scs_st_t;

    ////////////////////////////////////////////////////////////////////////
    // fixed mask
    localparam logic [31:0] MASK_RPT = DNZ_SUPPORTED ? SCS_MASK_FULL
                                                     : SCS_MASK_DEFAULT;

    // zero field reads as default mask
    function automatic logic [31:0] eff_mask(input logic [31:0] m);
        eff_mask = (m == 32'h0000_0000) ? SCS_MASK_DEFAULT : m;
    endfunction

    // bits clear in mask are reserved and must not be written as one
    function automatic logic reserved_hit(input logic [31:0] v);
        // reserved bits fault, zero bits reserved, bit 6 without support
        reserved_hit = |(v & ~eff_mask(MASK_RPT));
    endfunction

    // image word to register lane selection
    function automatic logic [31:0] vword(input logic [127:0] v,
                                          input logic [1:0] lane);
        vword = v[lane*32 +: 32];
    endfunction

    logic [127:0]  vreg_q [SCS_VREG_N];
    logic [127:0]  vreg_d [SCS_VREG_N];
    logic [31:0]   csr_q, csr_d;
    logic [31:0]   flg_q, flg_d;
    scs_st_t       st_q, st_d;
    logic [6:0]    ptr_q, ptr_d;
    logic [6:0]    rptr_q, rptr_d;
    scs_mem_t      mem_q, mem_d;
    scs_rsp_t      rsp_q, rsp_d;
    logic [31:0]   rcsr_q, rcsr_d;   // csr staged during restore
    logic          rbad_q, rbad_d;
    logic          busy_q, busy_d;
    logic [2:0]    wv;
    logic [1:0]    wl;

    ////////////////////////////////////////////////////////////////////////
    // next state: operations, save and restore sequencing
    always_comb begin
        for (int i = 0; i < SCS_VREG_N; i++) begin
            vreg_d[i] = vreg_q[i];
        end
        csr_d  = csr_q;
        flg_d  = flg_q;
        st_d   = st_q;
        ptr_d  = ptr_q;
        rptr_d = rptr_q;
        rcsr_d = rcsr_q;
        rbad_d = rbad_q;
        mem_d  = '0;
        rsp_d  = '0;
        wv     = 3'((ptr_q - SCS_IMG_VREG) >> 2);
        wl     = 2'(ptr_q - SCS_IMG_VREG);
        case (st_q)
            SCS_IDLE: begin
                if (req_valid) begin
                    case (req.op)
                        SCS_OP_LOAD: begin
                            rsp_d.done = 1'b1;
                            if (reserved_hit(req.data)) begin
                                rsp_d.protection_fault = 1'b1;
                            end else begin
                                csr_d = req.data;
                            end
                        end
                        SCS_OP_VEC, SCS_OP_VWRITE: begin
                            rsp_d.done = 1'b1;
                            if (!req.vec_supported || !os_vec_enable) begin
                                rsp_d.invalid_opcode_fault = 1'b1;
                            end else if (req.op == SCS_OP_VWRITE) begin
                                vreg_d[req.idx] = req.vdata;
                            end
                        end
                        SCS_OP_QUERY: begin
                            rsp_d.done = 1'b1;
                            if (req.data == SCS_LEAF_FEAT) begin
                                rsp_d.result[SCS_FEAT_V1_BIT] = 1'b1;
                                rsp_d.result[SCS_FEAT_V2_BIT] = 1'b1;
                            end
                            flg_d[SCS_ID_FLAG_BIT] = req.data[SCS_ID_FLAG_BIT];
                        end
                        SCS_OP_SAVE: begin
                            st_d  = SCS_SAVE;
                            ptr_d = 7'h00;
                        end
                        SCS_OP_RESTORE: begin
                            st_d   = SCS_REST;
                            ptr_d  = 7'h00;
                            rbad_d = 1'b0;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            SCS_SAVE: begin
                // one image word per cycle, 128 words
                mem_d.valid = 1'b1;
                mem_d.we    = 1'b1;
                mem_d.addr  = ptr_q;
                if (ptr_q == SCS_IMG_CSR) begin
                    mem_d.data = csr_q;
                end else if (ptr_q == SCS_IMG_MASK) begin
                    // mask word, bit 6 with support
                    mem_d.data = MASK_RPT;
                end else if (ptr_q >= SCS_IMG_VREG &&
                             ptr_q < SCS_IMG_VREG + 7'h20) begin
                    mem_d.data = vword(vreg_q[wv], wl);
                end
                ptr_d = ptr_q + 7'h01;
                if (ptr_q == SCS_IMG_LAST) begin
                    st_d       = SCS_IDLE;
                    rsp_d.done = 1'b1;
                end
            end
            SCS_REST, SCS_RWAIT: begin
                // read issued, data back next cycle
                if (st_q == SCS_REST) begin
                    mem_d.valid = 1'b1;
                    mem_d.addr  = ptr_q;
                    ptr_d       = ptr_q + 7'h01;
                    if (ptr_q == SCS_IMG_LAST) begin
                        st_d = SCS_RWAIT;
                    end
                end
                if (st_q == SCS_RWAIT || ptr_q != 7'h00) begin
                    wv = 3'((rptr_q - SCS_IMG_VREG) >> 2);
                    wl = 2'(rptr_q - SCS_IMG_VREG);
                    if (rptr_q == SCS_IMG_CSR) begin
                        rcsr_d = mem_rdata;
                        rbad_d = reserved_hit(mem_rdata);
                    end else if (rptr_q >= SCS_IMG_VREG &&
                                 rptr_q < SCS_IMG_VREG + 7'h20) begin
                        vreg_d[wv][wl*32 +: 32] = mem_rdata;
                    end
                    rptr_d = rptr_q + 7'h01;
                end
                if (st_q == SCS_RWAIT) begin
                    st_d       = SCS_IDLE;
                    rsp_d.done = 1'b1;
                    rptr_d     = 7'h00;
                    if (rbad_q) begin
                        rsp_d.protection_fault = 1'b1;
                    end else begin
                        csr_d = rcsr_q;
                    end
                end
            end
            default: st_d = SCS_IDLE;
        endcase
        // soft init touches nothing here
        // busy follows the next state so the output is a flop
        busy_d = (st_d != SCS_IDLE);
    end

    ////////////////////////////////////////////////////////////////////////
    // registers; soft init deliberately has no effect on this state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < SCS_VREG_N; i++) begin
                vreg_q[i] <= '0;
            end
            csr_q  <= SCS_CSR_RESET;
            flg_q  <= '0;
            st_q   <= SCS_IDLE;
            ptr_q  <= '0;
            rptr_q <= '0;
            rcsr_q <= '0;
            rbad_q <= 1'b0;
            busy_q <= 1'b0;
            mem_q  <= '0;
            rsp_q  <= '0;
        end else if (clk_en) begin
            for (int i = 0; i < SCS_VREG_N; i++) begin
                vreg_q[i] <= vreg_d[i];
            end
            csr_q  <= csr_d;
            flg_q  <= flg_d;
            st_q   <= st_d;
            ptr_q  <= ptr_d;
            rptr_q <= rptr_d;
            rcsr_q <= rcsr_d;
            rbad_q <= rbad_d;
            busy_q <= busy_d;
            mem_q  <= mem_d;
            rsp_q  <= rsp_d;
        end
    end

    // outputs straight from flops
    assign mem                 = mem_q;
    assign rsp                 = rsp_q;
    assign busy                = busy_q;
    assign simd_control_status = csr_q;
    assign flags_register      = flg_q;
endmodule

// file: src/scs_pkg.sv
package scs_pkg;
    localparam int SCS_VREG_W     = 128;
    localparam int SCS_VREG_N     = 8;
    localparam int SCS_IDX_W      = 3;
    localparam int SCS_CSR_W      = 32;
    localparam int SCS_WORD_W     = 32;
    // save image: 512 bytes as 128 words of 32 bits
    localparam int SCS_IMG_WORDS  = 128;
    localparam int SCS_WADDR_W    = 7;
    // csr field positions
    localparam int SCS_FLAG_LO    = 0;
    localparam int SCS_FLAG_HI    = 5;
    localparam int SCS_DNZ_BIT    = 6;
    localparam int SCS_MASK_LO    = 7;
    localparam int SCS_MASK_HI    = 12;
    localparam int SCS_RC_LO      = 13;
    localparam int SCS_RC_HI      = 14;
    localparam int SCS_FTZ_BIT    = 15;
    localparam logic [31:0] SCS_CSR_RESET   = 32'h0000_1F80;
    localparam logic [31:0] SCS_MASK_DEFAULT = 32'h0000_FFBF;
    localparam logic [31:0] SCS_MASK_FULL    = 32'h0000_FFFF;
    localparam logic [1:0]  SCS_RC_NEAREST   = 2'h0;
    // image layout (word indices): csr at byte 24, mask at bytes 28..31
    localparam logic [6:0] SCS_IMG_CSR   = 7'h06;
    localparam logic [6:0] SCS_IMG_MASK  = 7'h07;
    localparam logic [6:0] SCS_IMG_VREG  = 7'h28;
    localparam logic [6:0] SCS_IMG_LAST  = 7'h7F;
    // feature query
    localparam logic [31:0] SCS_LEAF_FEAT = 32'h0000_0001;
    localparam int SCS_FEAT_V1_BIT = 25;
    localparam int SCS_FEAT_V2_BIT = 26;
    localparam int SCS_ID_FLAG_BIT = 21;

    typedef enum logic [2:0] {
        SCS_OP_NONE, SCS_OP_LOAD, SCS_OP_SAVE, SCS_OP_RESTORE,
        SCS_OP_QUERY, SCS_OP_VEC, SCS_OP_VWRITE
    } scs_op_t;

    typedef struct packed {
        scs_op_t                 op;
        logic [31:0]             data;  // csr value, leaf or flags
        logic [2:0]              idx;   // vector register number
        logic [127:0]            vdata;
        logic                    vec_supported;
    } scs_req_t;

    typedef struct packed {
        logic                    valid;
        logic                    we;
        logic [6:0]              addr;
        logic [31:0]             data;
    } scs_mem_t;

    typedef struct packed {
        logic                    done;
        logic                    protection_fault;
        logic                    invalid_opcode_fault;
        logic [31:0]             result;
    } scs_rsp_t;
endpackage

// file: bench/scs_properties.sv
`timescale 1ns/1ps
module scs_properties #(
    parameter bit DNZ_SUPPORTED = 1'b1
) (
    // clock and reset
    input wire logic         clk,
    input wire logic         rst_n,
    // request side
    input wire logic         clk_en,
    input wire logic         init_n,
    input wire logic         req_valid,
    input scs_pkg::scs_req_t req,
    input wire logic         os_vec_enable,
    // answer side
    input scs_pkg::scs_mem_t mem,
    input scs_pkg::scs_rsp_t rsp,
    input wire logic         busy,
    input wire logic [31:0]  simd_control_status,
    input wire logic [31:0]  flags_register
);
    import scs_pkg::*;
    // reported mask follows the build choice only, never the csr
    localparam logic [31:0] MASK = DNZ_SUPPORTED ? SCS_MASK_FULL
                                                 : SCS_MASK_DEFAULT;
    logic take;
    assign take = req_valid && !busy && clk_en;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_rst_csr;
        $rose(rst_n) |-> simd_control_status == SCS_CSR_RESET;
    endproperty
    a_rst_csr: assert property (p_rst_csr)
        else $error("csr wrong after reset");
    property p_rst_fields;
        $rose(rst_n) |-> simd_control_status[15:13] == 3'h0
            && simd_control_status[6:0] == 7'h00;
    endproperty
    a_rst_fields: assert property (p_rst_fields)
        else $error("csr fields wrong after reset");
    property p_init_hold;
        !init_n && !busy && !req_valid |=> $stable(simd_control_status);
    endproperty
    a_init_hold: assert property (p_init_hold)
        else $error("csr moved under soft init");
    property p_load_bad;
        take && req.op == SCS_OP_LOAD && (req.data & ~MASK) != 32'h0
            |=> rsp.done && rsp.protection_fault
            && $stable(simd_control_status);
    endproperty
    a_load_bad: assert property (p_load_bad)
        else $error("reserved write not refused");
    property p_load_good;
        take && req.op == SCS_OP_LOAD && (req.data & ~MASK) == 32'h0
            |=> !rsp.protection_fault
            && simd_control_status == $past(req.data);
    endproperty
    a_load_good: assert property (p_load_good)
        else $error("legal csr write not applied");
    property p_vec_ud;
        take && (req.op == SCS_OP_VEC || req.op == SCS_OP_VWRITE)
            && (!req.vec_supported || !os_vec_enable)
            |=> rsp.done && rsp.invalid_opcode_fault;
    endproperty
    a_vec_ud: assert property (p_vec_ud)
        else $error("vector op not refused");
    property p_query;
        take && req.op == SCS_OP_QUERY && req.data == SCS_LEAF_FEAT
            |=> rsp.result[26:25] == 2'h3;
    endproperty
    a_query: assert property (p_query)
        else $error("feature bits missing");
    property p_mask_word;
        mem.valid && mem.we && mem.addr == SCS_IMG_MASK
            |-> mem.data == MASK;
    endproperty
    a_mask_word: assert property (p_mask_word)
        else $error("image mask word wrong");
    property p_save_done;
        take && req.op == SCS_OP_SAVE |-> ##[1:130] rsp.done;
    endproperty
    a_save_done: assert property (p_save_done)
        else $error("save did not finish");
    c_restore: cover property (take && req.op == SCS_OP_RESTORE);
    c_gp: cover property (rsp.done && rsp.protection_fault);
    c_ud: cover property (rsp.done && rsp.invalid_opcode_fault);
endmodule
bind scs_top scs_properties #(.DNZ_SUPPORTED(DNZ_SUPPORTED)) props_inst (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .init_n(init_n),
    .req_valid(req_valid), .req(req), .os_vec_enable(os_vec_enable),
    .mem(mem), .rsp(rsp), .busy(busy),
    .simd_control_status(simd_control_status),
    .flags_register(flags_register));

// file: bench/tb.sv
`timescale 1ns/1ps
module tb;
    import scs_pkg::*;
    localparam logic [127:0] PAT = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        init_n = 1'b1;
    logic        os_vec_enable = 1'b1;
    logic        req_valid = 1'b0;
    scs_req_t    req = '0;
    scs_mem_t    mem;
    logic [31:0] mem_rdata;
    logic [31:0] idle_rdata = 32'h0;
    scs_rsp_t    rsp;
    scs_rsp_t    got;
    logic        busy;
    logic [31:0] simd_control_status;
    logic [31:0] flags_register;
    logic [31:0] img [128];
    logic [31:0] saved [128];
    int          fail_count = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          k;
    always #2.5 clk = ~clk;
    // bit 6 reserved build, so the default mask is reported
    scs_top #(.DNZ_SUPPORTED(1'b0)) scs_top_inst (
        .clk(clk), .rst_n(rst_n), .clk_en(1'b1), .init_n(init_n),
        .os_vec_enable(os_vec_enable), .req_valid(req_valid), .req(req),
        .mem(mem), .mem_rdata(mem_rdata), .rsp(rsp), .busy(busy),
        .simd_control_status(simd_control_status),
        .flags_register(flags_register));
    ////////////////////////////////////////////////////////////////////
    // image memory; idle read data toggles so stale values never match
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (mem.valid && mem.we) saved[mem.addr] <= mem.data;
        idle_rdata <= ~idle_rdata;
        if (cycles == 5000) begin
            fail_count++;
            end_of_test();
        end
    end
    // the design samples read data at the edge after showing the address
    assign mem_rdata = (mem.valid && !mem.we) ? img[mem.addr] : idle_rdata;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one request, then wait a bounded time for its done pulse
    task automatic do_op(input scs_op_t op, input logic [31:0] d,
                         input logic [127:0] v, input logic sup);
        int n;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{op, d, 3'h7, v, sup};
        for (n = 0; n < 200; n++) begin
            @(posedge clk);
            req_valid <= 1'b0;
            #1;
            if (rsp.done === 1'b1) break;
        end
        got = rsp;
        check({31'h0, rsp.done}, 32'h1);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        for (k = 0; k < 128; k++) img[k] = 32'h0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        init_n <= 1'b0;
        #1;
        check(simd_control_status, 32'h0000_1F80);
        repeat (3) @(posedge clk);
        init_n <= 1'b1;
        #1;
        check(simd_control_status, 32'h0000_1F80);
        // reserved bit 6, then bit 16, then a legal value
        do_op(SCS_OP_LOAD, 32'h0000_1FC0, '0, 1'b0);
        check({31'h0, got.protection_fault}, 32'h1);
        do_op(SCS_OP_LOAD, 32'h0001_1F80, '0, 1'b0);
        check({31'h0, got.protection_fault}, 32'h1);
        check(simd_control_status, 32'h0000_1F80);
        do_op(SCS_OP_LOAD, 32'h0000_A03F & SCS_MASK_DEFAULT, '0, 1'b0);
        check(simd_control_status, 32'h0000_A03F);
        // both vector ops, unsupported then supported
        for (k = 0; k < 4; k++) begin
            do_op(k[0] ? SCS_OP_VWRITE : SCS_OP_VEC, '0, PAT, k[1]);
            check({31'h0, got.invalid_opcode_fault}, {31'h0, !k[1]});
        end
        @(posedge clk);
        os_vec_enable <= 1'b0;
        do_op(SCS_OP_VEC, '0, '0, 1'b1);
        check({31'h0, got.invalid_opcode_fault}, 32'h1);
        os_vec_enable <= 1'b1;
        do_op(SCS_OP_QUERY, 32'h0000_0001, '0, 1'b0);
        check({got.result[26:25], flags_register[21]}, 32'h6);
        do_op(SCS_OP_QUERY, 32'h0020_0000, '0, 1'b0);
        check({31'h0, flags_register[21]}, 32'h1);
        do_op(SCS_OP_SAVE, '0, '0, 1'b0);
        check(saved[6], 32'h0000_A03F);
        check(saved[7], 32'h0000_FFBF);
        for (k = 0; k < 4; k++) begin
            check(saved[40 + k], 32'h0);
            check(saved[68 + k], PAT[32 * k +: 32]);
            img[40 + k] = ~PAT[32 * k +: 32];
        end
        img[6] = 32'h0000_7F80;
        do_op(SCS_OP_RESTORE, '0, '0, 1'b0);
        check(simd_control_status, 32'h0000_7F80);
        img[6] = 32'h0000_0040;
        do_op(SCS_OP_RESTORE, '0, '0, 1'b0);
        check({31'h0, got.protection_fault}, 32'h1);
        check(simd_control_status, 32'h0000_7F80);
        do_op(SCS_OP_SAVE, '0, '0, 1'b0);
        for (k = 0; k < 4; k++) check(saved[40 + k], img[40 + k]);
        end_of_test();
    end
endmodule
